// ### pkg/fifo_map.vh
// constants and register map of the dual clock fifo with programmable flags
`ifndef FIFO_MAP_VH
`define FIFO_MAP_VH

// =====================================================
// register offsets on the axi4-lite bus
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_COUNT     8'h08
`define REG_OFFSETS   8'h0C

// =====================================================
// field positions
`define CTRL_PRS_BIT  0
`define ST_FIRST_WORD_FALLTHROUGH_MODE_BIT   0
`define ST_PAR_BIT    1
`define ST_EMPTY_BIT  2
`define ST_FULL_BIT   3
`define ST_OVAL_BIT   4

// =====================================================
// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// =====================================================
// default flag offsets and timing counts
`define OFS_DEF_SMALL 16'h007F
`define OFS_DEF_LARGE 16'h03FF
`define FIRST_WORD_FALLTHROUGH_MODE_LAST_TR  2'h2
`define RT_HOLD_EDGES 2'h2

`endif

// ### rtl/dual_clock_fifo_prog_flags.v
// first-in first-out buffer with programmable flags, sampled pin clocks and axi4-lite status
`include "fifo_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_prog_flags #(
  parameter DEPTH = 32768,
  parameter DW    = 18
) (
  // system clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // write side pins
  input  wire        i_wclk,
  input  wire        i_write_enable_n,
  input  wire        i_serial_load_enable_n,
  input  wire [17:0] i_write_data_in,
  // read side pins
  input  wire        i_rclk,
  input  wire        i_read_enable_n,
  input  wire        i_output_enable_n,
  input  wire        i_retransmit_n,
  // reset and configuration pins
  input  wire        i_master_reset_n,
  input  wire        i_partial_reset_n,
  input  wire        i_mode_select_serial_in,
  input  wire        i_offset_access_n,
  // data output bus with its enable
  output reg  [17:0] o_read_data_out,
  output reg         o_read_data_oe,
  // status flags, active low
  output reg         o_full_or_input_ready,
  output reg         o_empty_or_output_ready,
  output reg         o_half_full_n,
  output reg         o_almost_full_n,
  output reg         o_almost_empty_n,
  // axi4-lite write channels
  input  wire        i_awvalid,
  input  wire [7:0]  i_awaddr,
  output reg         o_awready,
  input  wire        i_wvalid,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  output reg         o_wready,
  output reg         o_bvalid,
  output reg  [1:0]  o_bresp,
  input  wire        i_bready,
  // axi4-lite read channels
  input  wire        i_arvalid,
  input  wire [7:0]  i_araddr,
  output reg         o_arready,
  output reg         o_rvalid,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  input  wire        i_rready
);

  localparam AW = $clog2(DEPTH);
  localparam PW = 29;

  // =====================================================
  // reset release
  reg rst_meta;
  reg rst_n;

  // async assert, two-flop release
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // =====================================================
  // pin synchronisers
  wire [PW-1:0] pins_s;
  wire          wclk_s;
  wire          rclk_s;
  wire          wen_n_s;
  wire          sen_n_s;
  wire          ren_n_s;
  wire          oe_n_s;
  wire          rt_n_s;
  wire          mrs_n_s;
  wire          prs_n_s;
  wire          si_s;
  wire          ld_n_s;
  wire [17:0]   din_s;

  // control pins idle high, mode select serial input and clocks idle low
  pin_sync #(
    .W    (PW),
    .INIT ({11'h1FD, 18'h00000})
  ) u_pins (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_pins  ({i_wclk, i_rclk, i_write_enable_n, i_serial_load_enable_n, i_read_enable_n,
               i_output_enable_n, i_retransmit_n, i_master_reset_n, i_partial_reset_n,
               i_mode_select_serial_in, i_offset_access_n, i_write_data_in}),
    .o_sync  (pins_s)
  );

  assign {wclk_s, rclk_s, wen_n_s, sen_n_s, ren_n_s, oe_n_s, rt_n_s,
          mrs_n_s, prs_n_s, si_s, ld_n_s, din_s} = pins_s;

  // =====================================================
  // edge detection on the sampled pin clocks
  reg  wclk_d;
  reg  rclk_d;
  wire wr_edge = wclk_s & ~wclk_d;
  wire rd_rise = rclk_s & ~rclk_d;
  wire rd_tran = rclk_s ^ rclk_d;

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      wclk_d <= wclk_s;
      rclk_d <= rclk_s;
    end
  end

  // =====================================================
  // configuration and offset registers
  reg          first_word_fallthrough_mode_mode;
  reg          par_mode;
  reg [AW-1:0] empty_ofs;
  reg [AW-1:0] full_ofs;
  reg          ofs_wsel;
  reg          soft_prs;

  wire [15:0] ofs_small = `OFS_DEF_SMALL;
  wire [15:0] ofs_large = `OFS_DEF_LARGE;
  wire        in_mrs    = ~mrs_n_s;
  wire        in_reset  = ~mrs_n_s | ~prs_n_s | soft_prs;

  // offsets survive partial reset; master reset reloads the defaults
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_word_fallthrough_mode_mode <= 1'b0;
      par_mode  <= 1'b1;
      empty_ofs <= {AW{1'b0}};
      full_ofs  <= {AW{1'b0}};
      ofs_wsel  <= 1'b0;
    end else if (in_mrs) begin
      first_word_fallthrough_mode_mode <= si_s;
      par_mode  <= ~ld_n_s;
      empty_ofs <= ld_n_s ? ofs_large[AW-1:0] : ofs_small[AW-1:0];
      full_ofs  <= ld_n_s ? ofs_large[AW-1:0] : ofs_small[AW-1:0];
      ofs_wsel  <= 1'b0;
    end else if (in_reset) begin
      ofs_wsel  <= 1'b0;
    end else if (wr_edge && !ld_n_s) begin
      if (par_mode && !wen_n_s) begin
        if (!ofs_wsel) begin
          empty_ofs <= din_s[AW-1:0];
        end else begin
          full_ofs <= din_s[AW-1:0];
        end
        ofs_wsel <= ~ofs_wsel;
      end else if (!par_mode && !sen_n_s) begin
        {full_ofs, empty_ofs} <= {si_s, full_ofs, empty_ofs[AW-1:1]};
      end
    end
  end

  // =====================================================
  // pointers and storage
  reg  [AW:0]   wptr;
  reg  [AW:0]   rptr;
  wire [AW:0]   count    = wptr - rptr;
  wire [AW:0]   cap      = {1'b1, {AW{1'b0}}};
  wire [AW:0]   half     = {2'b01, {(AW-1){1'b0}}};
  wire          is_empty = (count == {(AW+1){1'b0}});
  wire          is_full  = (count == cap);
  wire [DW-1:0] mem_q;
  wire          mem_we   = ~in_reset & wr_edge & ~wen_n_s & ld_n_s & ~is_full;

  // write pointer; both pointers live in this clock, so the compare is exact
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= {(AW+1){1'b0}};
    end else if (in_reset) begin
      wptr <= {(AW+1){1'b0}};
    end else if (mem_we) begin
      wptr <= wptr + {{AW{1'b0}}, 1'b1};
    end
  end

  fifo_storage #(
    .DW (DW),
    .AW (AW)
  ) u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (wptr[AW-1:0]),
    .i_wdata (din_s),
    .i_raddr (rptr[AW-1:0]),
    .o_rdata (mem_q)
  );

  // =====================================================
  // read side: output register, fall-through and retransmit
  reg       out_valid;
  reg [1:0] fall_cnt;
  reg [1:0] rt_hold;
  reg       ofs_rsel;

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr            <= {(AW+1){1'b0}};
      o_read_data_out <= 18'h00000;
      out_valid       <= 1'b0;
      fall_cnt        <= 2'h0;
      rt_hold         <= 2'h0;
      ofs_rsel        <= 1'b0;
    end else if (in_reset) begin
      rptr            <= {(AW+1){1'b0}};
      o_read_data_out <= 18'h00000;
      out_valid       <= 1'b0;
      fall_cnt        <= 2'h0;
      rt_hold         <= 2'h0;
      ofs_rsel        <= 1'b0;
    end else if (rd_rise && !rt_n_s) begin
      rptr      <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      fall_cnt  <= 2'h0;
      rt_hold   <= `RT_HOLD_EDGES;
    end else if (rd_rise && !ren_n_s && !ld_n_s) begin
      o_read_data_out <= ofs_rsel ? {{(18-AW){1'b0}}, full_ofs} : {{(18-AW){1'b0}}, empty_ofs};
      ofs_rsel        <= ~ofs_rsel;
      if (rt_hold != 2'h0) begin
        rt_hold <= rt_hold - 2'h1;
      end
    end else begin
      if (rd_rise && rt_hold != 2'h0) begin
        rt_hold <= rt_hold - 2'h1;
      end
      if (first_word_fallthrough_mode_mode) begin
        if (!out_valid) begin
          // counts transitions only while a word waits in memory
          if (rd_tran && !is_empty && rt_hold == 2'h0) begin
            if (fall_cnt == `FIRST_WORD_FALLTHROUGH_MODE_LAST_TR) begin
              o_read_data_out <= mem_q;
              rptr            <= rptr + {{AW{1'b0}}, 1'b1};
              out_valid       <= 1'b1;
              fall_cnt        <= 2'h0;
            end else begin
              fall_cnt <= fall_cnt + 2'h1;
            end
          end
        end else if (rd_rise && !ren_n_s) begin
          if (!is_empty) begin
            o_read_data_out <= mem_q;
            rptr            <= rptr + {{AW{1'b0}}, 1'b1};
          end else begin
            out_valid <= 1'b0;
          end
        end
      end else if (rd_rise && !ren_n_s && !is_empty) begin
        o_read_data_out <= mem_q;
        rptr            <= rptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // =====================================================
  // registered flags and output enable
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_read_data_oe          <= 1'b0;
      o_full_or_input_ready   <= 1'b1;
      o_empty_or_output_ready <= 1'b0;
      o_half_full_n           <= 1'b1;
      o_almost_full_n         <= 1'b1;
      o_almost_empty_n        <= 1'b0;
    end else begin
      o_read_data_oe <= ~oe_n_s;
      if (first_word_fallthrough_mode_mode) begin
        o_full_or_input_ready   <= is_full;
        o_empty_or_output_ready <= ~(out_valid & (rt_hold == 2'h0));
      end else begin
        o_full_or_input_ready   <= ~is_full;
        o_empty_or_output_ready <= ~(is_empty | (rt_hold != 2'h0));
      end
      o_half_full_n    <= ~(count > half);
      o_almost_full_n  <= ~(count > (cap - {1'b0, full_ofs}));
      o_almost_empty_n <= ~(count < {1'b0, empty_ofs});
    end
  end

  // =====================================================
  // axi4-lite write path
  reg        aw_got;
  reg        w_got;
  reg [7:0]  wr_addr;
  reg [31:0] wr_data;
  reg [3:0]  wr_strb;

  // each channel taken once, response after both
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RESP_OKAY;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h00000000;
      wr_strb   <= 4'h0;
      soft_prs  <= 1'b0;
    end else begin
      soft_prs <= 1'b0;
      if (!aw_got && !o_bvalid) begin
        o_awready <= 1'b1;
      end
      if (!w_got && !o_bvalid) begin
        o_wready <= 1'b1;
      end
      if (o_awready && i_awvalid) begin
        aw_got    <= 1'b1;
        wr_addr   <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        w_got    <= 1'b1;
        wr_data  <= i_wdata;
        wr_strb  <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (aw_got && w_got && !o_bvalid) begin
        o_bvalid <= 1'b1;
        aw_got   <= 1'b0;
        w_got    <= 1'b0;
        case (wr_addr)
          `REG_CTRL: begin
            o_bresp  <= `RESP_OKAY;
            soft_prs <= wr_strb[0] & wr_data[`CTRL_PRS_BIT];
          end
          `REG_STATUS, `REG_COUNT, `REG_OFFSETS: begin
            o_bresp <= `RESP_OKAY; // read-only, write ignored
          end
          default: begin
            o_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // =====================================================
  // axi4-lite read path
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `RESP_OKAY;
    end else begin
      if (!o_rvalid && !o_arready) begin
        o_arready <= 1'b1;
      end
      if (o_arready && i_arvalid) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rresp   <= `RESP_OKAY;
        o_rdata   <= 32'h00000000;
        case (i_araddr)
          `REG_CTRL: begin
            o_rdata <= 32'h00000000;
          end
          `REG_STATUS: begin
            o_rdata[`ST_FIRST_WORD_FALLTHROUGH_MODE_BIT]  <= first_word_fallthrough_mode_mode;
            o_rdata[`ST_PAR_BIT]   <= par_mode;
            o_rdata[`ST_EMPTY_BIT] <= is_empty;
            o_rdata[`ST_FULL_BIT]  <= is_full;
            o_rdata[`ST_OVAL_BIT]  <= out_valid;
          end
          `REG_COUNT: begin
            o_rdata <= {{(31-AW){1'b0}}, count};
          end
          `REG_OFFSETS: begin
            o_rdata <= {{(16-AW){1'b0}}, full_ofs, {(16-AW){1'b0}}, empty_ofs};
          end
          default: begin
            o_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/fifo_storage.v
// flip-flop storage array with one write port and one read port
`timescale 1ns/100ps
`default_nettype none
module fifo_storage #(
  parameter DW = 18,
  parameter AW = 15
) (
  // clock
  input  wire          i_clk,
  // write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [DW-1:0] i_wdata,
  // read port, combinational
  input  wire [AW-1:0] i_raddr,
  output wire [DW-1:0] o_rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // =====================================================
  // no reset on the array: contents are undefined until written
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];

endmodule
`default_nettype wire

// ### rtl/pin_sync.v
// two flip-flop synchroniser for a bus of pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter           W    = 8,
  parameter [W-1:0]   INIT = {W{1'b0}}
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_rst_n,
  // pins in, synchronised copy out
  input  wire [W-1:0] i_pins,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] meta;

  // =====================================================
  // first stage is read by the second stage only
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= INIT;
      o_sync <= INIT;
    end else begin
      meta   <= i_pins;
      o_sync <= meta;
    end
  end

endmodule
`default_nettype wire

// ### sim/dual_clock_fifo_prog_flags_bench.sv
// self-checking bench of the fifo with programmable flags
`include "fifo_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_prog_flags_bench;
  logic        i_clk, i_rst_b, i_partial_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, rd;
  logic [3:0]  i_wstrb;
  logic [1:0]  rs;
  logic [29:0] sv;
  wire         i_wclk, i_write_enable_n, i_serial_load_enable_n, i_rclk, i_read_enable_n;
  wire         i_output_enable_n, i_retransmit_n, i_master_reset_n, i_mode_select_serial_in;
  wire         i_offset_access_n, o_read_data_oe, o_full_or_input_ready, o_empty_or_output_ready;
  wire         o_half_full_n, o_almost_full_n, o_almost_empty_n, o_awready, o_wready, o_bvalid;
  wire         o_arready, o_rvalid;
  wire [17:0]  i_write_data_in, o_read_data_out;
  wire [1:0]   o_bresp, o_rresp;
  wire [31:0]  o_rdata;
  int          errors, num_checks, cyc;
  dual_clock_fifo_prog_flags DUT (.*);
  fifo_pin_partner P (.i_clk, .o_wclk(i_wclk), .o_wen_n(i_write_enable_n), .o_sen_n(i_serial_load_enable_n),
    .o_wd(i_write_data_in), .o_rclk(i_rclk), .o_ren_n(i_read_enable_n), .o_oe_n(i_output_enable_n),
    .o_rt_n(i_retransmit_n), .o_mrs_n(i_master_reset_n), .o_si(i_mode_select_serial_in),
    .o_ld_n(i_offset_access_n));
  // =====================================
  // clock, and a cycle ceiling against hangs
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results;
    end
  end
  task results;
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // =====================================
  // register bus master
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    ga = 0;
    gw = 0;
    @(posedge i_clk);
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    i_awaddr <= a;
    i_wdata  <= d;
    while (!(ga && gw)) begin
      @(posedge i_clk);
      if (o_awready && !ga) begin
        ga = 1;
        i_awvalid <= 1'b0;
      end
      if (o_wready && !gw) begin
        gw = 1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (!o_bvalid);
    rs = o_bresp;
    i_bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge i_clk);
    {i_arvalid, i_rready} <= 2'h3;
    i_araddr <= a;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_rvalid);
    rd = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask
  // =====================================
  // standard timing, parallel offsets, retransmit, partial reset
  task t_std;
    P.mreset(1'b0, 1'b0);
    axr(`REG_STATUS); chk(rd[4:0], 5'h06, "std status");
    axr(`REG_OFFSETS); chk(rd, 32'h007F007F, "std defaults");
    chk(o_empty_or_output_ready, 1'b0, "empty flag");
    chk(o_full_or_input_ready, 1'b1, "full flag");
    P.wpulse(1'b0, 1'b1, 1'b0, 1'b0, 18'h00002);
    P.wpulse(1'b0, 1'b1, 1'b0, 1'b0, 18'h07FFE);
    axr(`REG_OFFSETS); chk(rd, 32'h7FFE0002, "parallel offsets");
    for (int i = 1; i < 4; i++) P.wpulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h3C3C0 + 18'(i));
    chk(o_read_data_out, 32'h0, "no fall through");
    axr(`REG_COUNT); chk(rd, 32'd3, "count");
    chk(o_empty_or_output_ready, 1'b1, "not empty");
    chk(o_almost_empty_n, 1'b1, "almost empty");
    chk(o_almost_full_n, 1'b0, "almost full");
    chk(o_half_full_n, 1'b1, "below half");
    P.rpulse(1'b1, 1'b1, 1'b1); chk(o_read_data_out, 32'h0, "idle read");
    P.rpulse(1'b0, 1'b1, 1'b1); chk(o_read_data_out, 32'h3C3C1, "first word");
    P.rpulse(1'b0, 1'b1, 1'b1); chk(o_read_data_out, 32'h3C3C2, "second word");
    P.rpulse(1'b1, 1'b0, 1'b1); chk(o_empty_or_output_ready, 1'b0, "retransmit empty");
    P.rpulse(1'b1, 1'b1, 1'b1);
    P.rpulse(1'b1, 1'b1, 1'b1);
    P.rpulse(1'b0, 1'b1, 1'b1); chk(o_read_data_out, 32'h3C3C1, "reread");
    P.rpulse(1'b0, 1'b1, 1'b0); chk(o_read_data_out, 32'h2, "empty offset out");
    P.rpulse(1'b0, 1'b1, 1'b0); chk(o_read_data_out, 32'h7FFE, "full offset out");
    axw(`REG_CTRL, 32'h1); chk(rs, `RESP_OKAY, "ctrl resp");
    repeat (8) @(posedge i_clk);
    axr(`REG_COUNT); chk(rd, 32'd0, "partial count");
    chk(o_read_data_out, 32'h0, "partial data");
    axr(`REG_OFFSETS); chk(rd, 32'h7FFE0002, "partial keeps");
    axr(8'h40); chk(rs, `RESP_SLVERR, "unmapped"); chk(rd, 32'h0, "unmapped data");
  endtask
  // =====================================
  // fall-through timing, serial offsets, output enable
  task t_first_word_fallthrough_mode;
    P.mreset(1'b1, 1'b1);
    axr(`REG_STATUS); chk(rd[1:0], 2'h1, "first_word_fallthrough_mode status");
    axr(`REG_OFFSETS); chk(rd, 32'h03FF03FF, "first_word_fallthrough_mode defaults");
    sv = {15'd6, 15'd3};
    for (int i = 0; i < 30; i++) P.wpulse(1'b1, 1'b0, 1'b0, sv[i], 18'h00000);
    axr(`REG_OFFSETS); chk(rd, 32'h00060003, "serial offsets");
    chk(o_full_or_input_ready, 1'b0, "input ready");
    P.wpulse(1'b0, 1'b1, 1'b1, 1'b0, 18'h2A5A5);
    chk(o_empty_or_output_ready, 1'b1, "nothing out yet");
    chk(o_almost_empty_n, 1'b0, "almost empty low");
    P.rpulse(1'b1, 1'b1, 1'b1); chk(o_read_data_out, 32'h0, "two transitions");
    P.rpulse(1'b1, 1'b1, 1'b1); chk(o_read_data_out, 32'h2A5A5, "fell through");
    chk(o_empty_or_output_ready, 1'b0, "output ready");
    P.oe(1'b1); repeat (10) @(posedge i_clk); chk(o_read_data_oe, 1'b0, "bus released");
    P.oe(1'b0); repeat (10) @(posedge i_clk); chk(o_read_data_oe, 1'b1, "bus driven");
  endtask
  // =====================================
  // main sequence
  initial begin
    {i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    i_partial_reset_n = 1'b1;
    {i_awaddr, i_araddr} = 16'h0000;
    i_wdata = 32'h00000000;
    i_wstrb = 4'hF;
    {errors, num_checks} = 0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_std;
    t_first_word_fallthrough_mode;
    results;
  end
endmodule
`default_nettype wire

// ### sim/fifo_chk.sv
// assertions on the pin and register-bus ports of the fifo
`timescale 1ns/100ps
`default_nettype none
module fifo_chk (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // pins
  input wire logic        i_master_reset_n,
  input wire logic        i_output_enable_n,
  input wire logic [17:0] o_read_data_out,
  input wire logic        o_read_data_oe,
  input wire logic        o_half_full_n,
  input wire logic        o_almost_full_n,
  input wire logic        o_almost_empty_n,
  // register bus
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        i_rready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // =====================================
  // pins: windows of 8 leave room for the two-flop pin sampling
  a_oe_drive_on: assert property (!i_output_enable_n [*8] |-> o_read_data_oe)
    else $error("data bus not driven");
  a_oe_drive_off: assert property (i_output_enable_n [*8] |-> !o_read_data_oe)
    else $error("data bus still driven");
  a_reset_data_zero: assert property (!i_master_reset_n [*8] |-> o_read_data_out == 18'h0)
    else $error("output register not cleared");
  a_reset_flag_levels: assert property (!i_master_reset_n [*8] |->
    o_half_full_n && o_almost_full_n && !o_almost_empty_n)
    else $error("flags wrong in master reset");
  // =====================================
  // register bus handshakes
  a_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_r_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read response dropped");
  a_b_answers: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid)
    else $error("write response late");
  a_r_answers: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read response late");
  a_w_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during response");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken during response");
endmodule
bind dual_clock_fifo_prog_flags fifo_chk u_chk (.i_clk, .i_rst_b, .i_master_reset_n, .i_output_enable_n,
  .o_read_data_out, .o_read_data_oe, .o_half_full_n, .o_almost_full_n, .o_almost_empty_n, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bvalid, .o_bresp, .i_bready, .i_arvalid, .o_arready, .o_rvalid,
  .o_rdata, .o_rresp, .i_rready);
`default_nettype wire

// ### sim/fifo_pin_partner.sv
// pin-level model of the writing and reading logic
`timescale 1ns/100ps
`default_nettype none
module fifo_pin_partner (
  // system clock
  input  wire logic        i_clk,
  // write side
  output logic        o_wclk,
  output logic        o_wen_n,
  output logic        o_sen_n,
  output logic [17:0] o_wd,
  // read side
  output logic        o_rclk,
  output logic        o_ren_n,
  output logic        o_oe_n,
  output logic        o_rt_n,
  // reset and configuration
  output logic        o_mrs_n,
  output logic        o_si,
  output logic        o_ld_n
);
  // =====================================
  // idle levels; link clocks stand still between frames
  initial begin
    {o_wclk, o_rclk, o_oe_n, o_mrs_n, o_si} = 5'h00;
    {o_wen_n, o_sen_n, o_ren_n, o_rt_n, o_ld_n} = 5'h1F;
    o_wd = 18'h00000;
  end
  // mode and load levels picked while master reset is low
  task mreset(input logic fw, input logic ld);
    @(posedge i_clk);
    o_mrs_n <= 1'b0;
    o_si    <= fw;
    o_ld_n  <= ld;
    repeat (24) @(posedge i_clk);
    o_mrs_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_ld_n <= 1'b1;
    o_si   <= ~fw;
  endtask
  // one 68 ns write clock period; released data shows its inverse
  task wpulse(input logic wen, input logic serial_load_enable_n, input logic ld, input logic si, input logic [17:0] d);
    @(posedge i_clk);
    {o_wen_n, o_sen_n, o_ld_n, o_si} <= {wen, serial_load_enable_n, ld, si};
    o_wd <= d;
    repeat (8) @(posedge i_clk);
    o_wclk <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_wclk <= 1'b0;
    {o_wen_n, o_sen_n, o_ld_n, o_si} <= {3'h7, ~si};
    o_wd <= ~d;
  endtask
  // one read clock period, two transitions
  task rpulse(input logic ren, input logic rt, input logic ld);
    @(posedge i_clk);
    {o_ren_n, o_rt_n, o_ld_n} <= {ren, rt, ld};
    repeat (8) @(posedge i_clk);
    o_rclk <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_rclk <= 1'b0;
    {o_ren_n, o_rt_n, o_ld_n} <= 3'h7;
  endtask
  task oe(input logic v);
    @(posedge i_clk);
    o_oe_n <= v;
  endtask
endmodule
`default_nettype wire
